//--- srocr_regs.sv
// Reference and output configuration register bank of the synthesizer.
`timescale 1ns/1ps
module srocr_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire srocr_pkg::srocr_req_t req,
  input wire logic div_update,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output srocr_pkg::srocr_cfg_t cfg
);
  import srocr_pkg::*;

  logic [SROCR_NREG-1:0] wr_hit;
  logic [SROCR_NREG-1:0] rd_hit;
  logic [SROCR_NREG-1:0][7:0] reg_q;
  logic [SROCR_NREG-1:0][7:0] rd_term;
  logic [SROCR_NREG:0][7:0] rd_acc;
  logic [7:0] rdata_d;
  logic rvalid_d;
  logic [7:0] ref_q;
  logic [7:0] trk_q;
  logic [7:0] div_q;
  logic [7:0] out_q;
  logic [7:0] bld_q;
  srocr_div_t div_hold;
  srocr_div_t div_active_q;

  // Address decode, storage and read selection for every register.
  // An access to an offset outside the bank hits nothing, so a write
  // is dropped and a read answers zero.
  assign rd_acc[0] = 8'h00;
  genvar gi;
  generate
    for (gi = 0; gi < SROCR_NREG; gi++) begin : g_reg
      assign wr_hit[gi] = req.wr && (req.addr == SROCR_OFS_TAB[gi]);
      assign rd_hit[gi] = req.rd && (req.addr == SROCR_OFS_TAB[gi]);
      assign rd_term[gi] = rd_hit[gi] ? reg_q[gi] : 8'h00;
      assign rd_acc[gi+1] = rd_acc[gi] | rd_term[gi];
      srocr_byte_reg #(
        .RESET(SROCR_RST_TAB[gi]),
        .WMASK(SROCR_WM_TAB[gi])
      ) u_reg (
        .clk(clk),
        .rstn(rstn),
        .we(wr_hit[gi]),
        .wdata(req.wdata),
        .q(reg_q[gi])
      );
    end
  endgenerate

  // Named views of the stored bytes.
  assign ref_q = reg_q[SROCR_IDX_REF];
  assign trk_q = reg_q[SROCR_IDX_TRK];
  assign div_q = reg_q[SROCR_IDX_DIV];
  assign out_q = reg_q[SROCR_IDX_OUT];
  assign bld_q = reg_q[SROCR_IDX_BLD];

  // Read data is registered so the answer never depends on the request
  // wires combinationally; a read in the same cycle as a write to the
  // same register returns the old value.
  assign rdata_d = rd_acc[SROCR_NREG];
  assign rvalid_d = req.rd;

  // Read answer flip-flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // The stored division code is the holding copy; the active copy feeds
  // the divider and only moves on an update when buffering is selected.
  assign div_hold = srocr_div_t'(div_q[SROCR_DIV_SEL_MSB:SROCR_DIV_SEL_LSB]);

  srocr_dbuf u_dbuf (
    .clk(clk),
    .rstn(rstn),
    .db_sel(out_q[SROCR_OUT_DB_BIT]),
    .update(div_update),
    .hold(div_hold),
    .active_q(div_active_q)
  );

  // Reference path controls.
  assign cfg.reference_input_type = ref_q[SROCR_REF_TYPE_BIT];
  assign cfg.reference_doubler_enable = ref_q[SROCR_REF_DBL_BIT];
  assign cfg.reference_half_divider_enable =
    ref_q[SROCR_REF_HALF_BIT];

  // Tracking filter controls.
  assign cfg.tracking_reserved =
    trk_q[SROCR_TRK_RSV_MSB:SROCR_TRK_RSV_LSB];
  assign cfg.coef_manual = trk_q[SROCR_TRK_COEF_BIT];

  // The reserved-code flag is a flop of its own that loads exactly when
  // the active copy does, so the output stays a register and never
  // ripples through a compare on its way out.
  logic div_load;
  logic div_rsv_d;
  logic div_rsv_q;
  assign div_load = !out_q[SROCR_OUT_DB_BIT] || div_update;
  assign div_rsv_d = div_load ? (div_hold == SROCR_DIV_RSV) : div_rsv_q;

  // Reserved-code flag flip-flop; the reset division code is not reserved.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_rsv_q <= 1'b0;
    end else begin
      div_rsv_q <= div_rsv_d;
    end
  end

  // Feedback and division. Code seven is passed on but flagged, since
  // the divider has no defined ratio for it.
  assign cfg.feedback_source_select = div_q[SROCR_DIV_FB_BIT];
  assign cfg.division_ratio = div_active_q;
  assign cfg.division_reserved_code = div_rsv_q;

  // Output stage controls.
  assign cfg.reserved_mute_bit = out_q[SROCR_OUT_MUTE_BIT];
  assign cfg.division_double_buffer_select =
    out_q[SROCR_OUT_DB_BIT];
  assign cfg.unused_quadrupler_bit = out_q[SROCR_OUT_QUAD_BIT];
  assign cfg.output_doubler_path_enable =
    out_q[SROCR_OUT_DBL_BIT];
  assign cfg.main_output_enable = out_q[SROCR_OUT_EN_BIT];
  assign cfg.output_power_level =
    srocr_pwr_t'(out_q[SROCR_OUT_PWR_MSB:SROCR_OUT_PWR_LSB]);

  // Bleed current code, derived by software from N and pump current.
  assign cfg.bleed_current_code = bld_q;

  // Checks on the bank, all in the register clock domain.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // A write to one offset, and a read of it on the next cycle.
  sequence s_wr(logic [7:0] ofs);
    req.wr && (req.addr == ofs);
  endsequence

  sequence s_rd_clean(logic [7:0] ofs);
    req.rd && !req.wr && (req.addr == ofs);
  endsequence

  sequence s_rw(logic [7:0] ofs);
    s_wr(ofs) ##1 s_rd_clean(ofs);
  endsequence

  AST_REF_TYPE: assert property (
    s_wr(SROCR_OFS_REF) |=>
      cfg.reference_input_type == $past(req.wdata[SROCR_REF_TYPE_BIT]))
    else $error("reference input type did not follow the write");

  AST_REF_DOUBLER: assert property (
    s_wr(SROCR_OFS_REF) |=>
      cfg.reference_doubler_enable == $past(req.wdata[SROCR_REF_DBL_BIT]))
    else $error("reference doubler enable did not follow the write");

  AST_REF_HALF: assert property (
    s_wr(SROCR_OFS_REF) ##1 !(req.wr && (req.addr == SROCR_OFS_REF)) |=>
      cfg.reference_half_divider_enable ==
      $past(req.wdata[SROCR_REF_HALF_BIT], 2))
    else $error("reference half divider lost its written value");

  AST_TRK_RSV_READBACK: assert property (
    s_rw(SROCR_OFS_TRK) |=> rvalid_q &&
      rdata_q[SROCR_TRK_RSV_MSB:SROCR_TRK_RSV_LSB] ==
      $past(req.wdata[SROCR_TRK_RSV_MSB:SROCR_TRK_RSV_LSB], 2))
    else $error("tracking reserved field did not read back");

  AST_TRK_COEF: assert property (
    s_wr(SROCR_OFS_TRK) |=>
      cfg.coef_manual == $past(req.wdata[SROCR_TRK_COEF_BIT]))
    else $error("coefficient source did not follow the write");

  AST_DIV_FB: assert property (
    !(req.wr && (req.addr == SROCR_OFS_DIV)) |=>
      $stable(cfg.feedback_source_select))
    else $error("feedback source moved without a write");

  AST_DIV_IMMEDIATE: assert property (
    (req.wr && (req.addr == SROCR_OFS_DIV) &&
      !cfg.division_double_buffer_select) ##1
      !cfg.division_double_buffer_select |=>
      cfg.division_ratio ==
      $past(req.wdata[SROCR_DIV_SEL_MSB:SROCR_DIV_SEL_LSB], 2))
    else $error("unbuffered division did not take the written code");

  AST_DIV_RSV_FLAG: assert property (
    cfg.division_reserved_code == (cfg.division_ratio == SROCR_DIV_RSV))
    else $error("reserved division flag disagrees with the code");

  AST_DIV_HELD: assert property (
    (cfg.division_double_buffer_select && !div_update) |=>
      $stable(cfg.division_ratio))
    else $error("buffered division moved without an update");

  AST_DIV_LOAD: assert property (
    (cfg.division_double_buffer_select && div_update) |=>
      cfg.division_ratio == $past(div_hold))
    else $error("update did not load the holding division code");

  AST_OUT_READBACK: assert property (
    s_rw(SROCR_OFS_OUT) |=> rdata_q == ($past(req.wdata, 2) & SROCR_WM_OUT))
    else $error("output control did not read back its writable bits");

  AST_OUT_ENABLE: assert property (
    s_wr(SROCR_OFS_OUT) |=>
      cfg.main_output_enable == $past(req.wdata[SROCR_OUT_EN_BIT]))
    else $error("main output enable did not follow the write");

  AST_OUT_POWER: assert property (
    s_wr(SROCR_OFS_OUT) |=> cfg.output_power_level ==
      $past(req.wdata[SROCR_OUT_PWR_MSB:SROCR_OUT_PWR_LSB]))
    else $error("output power level did not follow the write");

  AST_BLEED_READBACK: assert property (
    s_rw(SROCR_OFS_BLD) |=> rvalid_q && rdata_q == $past(req.wdata, 2)
      && cfg.bleed_current_code == $past(req.wdata, 2))
    else $error("bleed current code did not read back");

  AST_REF_RO_ZERO: assert property (
    req.rd && (req.addr == SROCR_OFS_REF) |=>
      (rdata_q & ~SROCR_WM_REF) == 8'h00)
    else $error("reference read-only bits read nonzero");

  AST_DIV_RO_ZERO: assert property (
    req.rd && (req.addr == SROCR_OFS_DIV) |=>
      (rdata_q & ~SROCR_WM_DIV) == 8'h00)
    else $error("divider read-only bits read nonzero");

  AST_UNMAPPED_ZERO: assert property (
    req.rd && (rd_hit == '0) |=> rvalid_q && rdata_q == 8'h00)
    else $error("unmapped read did not answer zero");

  AST_TRK_RO_ZERO: assert property (
    req.rd && (req.addr == SROCR_OFS_TRK) |=>
      (rdata_q & ~SROCR_WM_TRK) == 8'h00)
    else $error("tracking read-only bits read nonzero");

  AST_OUT_RO_ZERO: assert property (
    req.rd && (req.addr == SROCR_OFS_OUT) |=>
      (rdata_q & ~SROCR_WM_OUT) == 8'h00)
    else $error("output control read-only bit read nonzero");

  AST_RVALID_ONE: assert property (
    req.rd |=> rvalid_q)
    else $error("read was not answered on the next cycle");

  AST_IDLE_ZERO: assert property (
    !req.rd |=> !rvalid_q && rdata_q == 8'h00)
    else $error("answer appeared without a read");

  AST_FB_WRITE: assert property (
    s_wr(SROCR_OFS_DIV) |=>
      cfg.feedback_source_select == $past(req.wdata[SROCR_DIV_FB_BIT]))
    else $error("feedback source did not follow the write");

  AST_OUT_DOUBLER: assert property (
    s_wr(SROCR_OFS_OUT) |=>
      cfg.output_doubler_path_enable == $past(req.wdata[SROCR_OUT_DBL_BIT]))
    else $error("output doubler path did not follow the write");

  AST_OUT_RSV_STORE: assert property (
    s_wr(SROCR_OFS_OUT) |=>
      cfg.reserved_mute_bit == $past(req.wdata[SROCR_OUT_MUTE_BIT]) &&
      cfg.unused_quadrupler_bit == $past(req.wdata[SROCR_OUT_QUAD_BIT]))
    else $error("output reserved bits did not store the write");

  AST_DB_SELECT: assert property (
    s_wr(SROCR_OFS_OUT) |=> cfg.division_double_buffer_select ==
      $past(req.wdata[SROCR_OUT_DB_BIT]))
    else $error("double buffer select did not follow the write");

  AST_REF_READBACK: assert property (
    s_rw(SROCR_OFS_REF) |=> rdata_q == ($past(req.wdata, 2) & SROCR_WM_REF))
    else $error("reference register did not read back");

  AST_DIV_READBACK: assert property (
    s_rw(SROCR_OFS_DIV) |=> rdata_q == ($past(req.wdata, 2) & SROCR_WM_DIV))
    else $error("divider register did not read back the stored code");

  AST_UNMAPPED_WRITE: assert property (
    req.wr && (wr_hit == '0) |=> $stable(reg_q))
    else $error("unmapped write changed a register");

  AST_BLEED_STABLE: assert property (
    !(req.wr && (req.addr == SROCR_OFS_BLD)) |=>
      $stable(cfg.bleed_current_code))
    else $error("bleed current code moved without a write");

endmodule : srocr_regs

//--- srocr_pkg.sv
// Package with offsets, field layout, reset values and types of the bank.
package srocr_pkg;

  // Bank geometry.
  localparam int SROCR_NREG = 5;
  localparam int SROCR_AW = 8;
  localparam int SROCR_DW = 8;

  // Register offsets.
  localparam logic [7:0] SROCR_OFS_REF = 8'h22;
  localparam logic [7:0] SROCR_OFS_TRK = 8'h23;
  localparam logic [7:0] SROCR_OFS_DIV = 8'h24;
  localparam logic [7:0] SROCR_OFS_OUT = 8'h25;
  localparam logic [7:0] SROCR_OFS_BLD = 8'h26;

  // Reset values.
  localparam logic [7:0] SROCR_RST_REF = 8'h00;
  localparam logic [7:0] SROCR_RST_TRK = 8'h00;
  localparam logic [7:0] SROCR_RST_DIV = 8'h80;
  localparam logic [7:0] SROCR_RST_OUT = 8'h07;
  localparam logic [7:0] SROCR_RST_BLD = 8'h32;

  // Writable bits; every other bit is read-only zero.
  localparam logic [7:0] SROCR_WM_REF = 8'h70;
  localparam logic [7:0] SROCR_WM_TRK = 8'h32;
  localparam logic [7:0] SROCR_WM_DIV = 8'hf0;
  localparam logic [7:0] SROCR_WM_OUT = 8'hbf;
  localparam logic [7:0] SROCR_WM_BLD = 8'hff;

  // Index of each register in the tables below.
  localparam int SROCR_IDX_REF = 0;
  localparam int SROCR_IDX_TRK = 1;
  localparam int SROCR_IDX_DIV = 2;
  localparam int SROCR_IDX_OUT = 3;
  localparam int SROCR_IDX_BLD = 4;

  // Tables, element 0 is the reference register.
  localparam logic [SROCR_NREG-1:0][7:0] SROCR_OFS_TAB = {SROCR_OFS_BLD,
    SROCR_OFS_OUT, SROCR_OFS_DIV, SROCR_OFS_TRK, SROCR_OFS_REF};
  localparam logic [SROCR_NREG-1:0][7:0] SROCR_RST_TAB = {SROCR_RST_BLD,
    SROCR_RST_OUT, SROCR_RST_DIV, SROCR_RST_TRK, SROCR_RST_REF};
  localparam logic [SROCR_NREG-1:0][7:0] SROCR_WM_TAB = {SROCR_WM_BLD,
    SROCR_WM_OUT, SROCR_WM_DIV, SROCR_WM_TRK, SROCR_WM_REF};

  // Field positions.
  localparam int SROCR_REF_TYPE_BIT = 6;
  localparam int SROCR_REF_DBL_BIT = 5;
  localparam int SROCR_REF_HALF_BIT = 4;
  localparam int SROCR_TRK_RSV_LSB = 4;
  localparam int SROCR_TRK_RSV_MSB = 5;
  localparam int SROCR_TRK_COEF_BIT = 1;
  localparam int SROCR_DIV_FB_BIT = 7;
  localparam int SROCR_DIV_SEL_LSB = 4;
  localparam int SROCR_DIV_SEL_MSB = 6;
  localparam int SROCR_OUT_MUTE_BIT = 7;
  localparam int SROCR_OUT_DB_BIT = 5;
  localparam int SROCR_OUT_QUAD_BIT = 4;
  localparam int SROCR_OUT_DBL_BIT = 3;
  localparam int SROCR_OUT_EN_BIT = 2;
  localparam int SROCR_OUT_PWR_LSB = 0;
  localparam int SROCR_OUT_PWR_MSB = 1;

  // Output division codes.
  typedef enum logic [2:0] {
    SROCR_DIV_1 = 3'h0, SROCR_DIV_2 = 3'h1, SROCR_DIV_4 = 3'h2,
    SROCR_DIV_8 = 3'h3, SROCR_DIV_16 = 3'h4, SROCR_DIV_32 = 3'h5,
    SROCR_DIV_64 = 3'h6, SROCR_DIV_RSV = 3'h7
  } srocr_div_t;

  // Output power codes: -4, -1, 2 and 5 dBm.
  typedef enum logic [1:0] {
    SROCR_PWR_M4 = 2'h0, SROCR_PWR_M1 = 2'h1,
    SROCR_PWR_P2 = 2'h2, SROCR_PWR_P5 = 2'h3
  } srocr_pwr_t;

  // One register access from the serial front end.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [SROCR_AW-1:0] addr;
    logic [SROCR_DW-1:0] wdata;
  } srocr_req_t;

  // Decoded configuration driven into the analog blocks.
  typedef struct packed {
    logic reference_input_type;
    logic reference_doubler_enable;
    logic reference_half_divider_enable;
    logic [1:0] tracking_reserved;
    logic coef_manual;
    logic feedback_source_select;
    srocr_div_t division_ratio;
    logic division_reserved_code;
    logic reserved_mute_bit;
    logic division_double_buffer_select;
    logic unused_quadrupler_bit;
    logic output_doubler_path_enable;
    logic main_output_enable;
    srocr_pwr_t output_power_level;
    logic [7:0] bleed_current_code;
  } srocr_cfg_t;

endpackage : srocr_pkg

//--- srocr_byte_reg.sv
// One 8-bit configuration register with a mask of writable bits.
`timescale 1ns/1ps
module srocr_byte_reg #(
  parameter logic [7:0] RESET = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  import srocr_pkg::*;

  logic [7:0] q_d;

  // Masked bits never store, so read-only positions stay zero.
  assign q_d = we ? (wdata & WMASK) : q;

  // Storage with its documented reset value.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= RESET & WMASK;
    end else begin
      q <= q_d;
    end
  end

endmodule : srocr_byte_reg

//--- srocr_dbuf.sv
// Active copy of the output division field, optionally double buffered.
`timescale 1ns/1ps
module srocr_dbuf (
  input wire logic clk,
  input wire logic rstn,
  input wire logic db_sel,
  input wire logic update,
  input wire srocr_pkg::srocr_div_t hold,
  output srocr_pkg::srocr_div_t active_q
);
  import srocr_pkg::*;

  srocr_div_t active_d;

  // Unbuffered the field tracks the register; buffered it waits for update.
  assign active_d = (!db_sel || update) ? hold : active_q;

  // The active field resets with the register's own division code.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_q <= srocr_div_t'(SROCR_RST_DIV[SROCR_DIV_SEL_MSB:
        SROCR_DIV_SEL_LSB]);
    end else begin
      active_q <= active_d;
    end
  end

endmodule : srocr_dbuf

//--- srocr_regs_tb.sv
// Self-checking bench for the reference and output configuration bank.
`timescale 1ns/1ps
module srocr_regs_tb;
  import srocr_pkg::*;
  logic clk;
  logic rstn;
  srocr_req_t req;
  logic div_update;
  logic [7:0] rdata_q;
  logic rvalid_q;
  srocr_cfg_t cfg;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rng;
  logic [7:0] mem [SROCR_NREG];
  logic [2:0] act;
  // Reset values and writable bits, kept apart from the package on purpose.
  logic [7:0] rst_val [SROCR_NREG] = '{8'h00, 8'h00, 8'h80, 8'h07, 8'h32};
  logic [7:0] wmask [SROCR_NREG] = '{8'h70, 8'h32, 8'hf0, 8'hbf, 8'hff};

  srocr_regs dut (
    .clk(clk),
    .rstn(rstn),
    .req(req),
    .div_update(div_update),
    .rdata_q(rdata_q),
    .rvalid_q(rvalid_q),
    .cfg(cfg)
  );

  // Free-running 200 MHz register clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cut a hang short; the run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      $display("[ERR] timeout expected finish seen hang");
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  function automatic int find(input logic [7:0] a);
    for (int i = 0; i < SROCR_NREG; i++) begin
      if (SROCR_OFS_TAB[i] === a) return i;
    end
    return -1;
  endfunction : find

  // Decoded fields as the model sees them, in struct order.
  function automatic srocr_cfg_t exp_cfg();
    return {mem[0][6:4], mem[1][5:4], mem[1][1], mem[2][7], act,
      act == 3'h7, mem[3][7], mem[3][5:0], mem[4]};
  endfunction : exp_cfg

  task automatic model_reset();
    for (int i = 0; i < SROCR_NREG; i++) mem[i] = rst_val[i];
    act = 3'h0;
  endtask : model_reset

  task automatic cmp_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_byte

  task automatic cmp_cfg(input srocr_cfg_t e);
    checks_done++;
    if (cfg !== e) begin
      errors++;
      $display("[ERR] cfg expected %h seen %h", e, cfg);
    end
  endtask : cmp_cfg

  // One access per edge; the model sees old contents for the read answer.
  task automatic op(input logic wr, input logic rd, input logic [7:0] a,
                    input logic [7:0] wd, input logic upd);
    int i;
    logic [7:0] erd;
    logic db;
    i = find(a);
    erd = (rd && i >= 0) ? mem[i] : 8'h00;
    db = mem[SROCR_IDX_OUT][5];
    req = '{wr: wr, rd: rd, addr: a, wdata: wd};
    div_update = upd;
    @(posedge clk);
    // The active code takes the stored code of before this edge.
    if (!db || upd) act = mem[SROCR_IDX_DIV][6:4];
    if (wr && i >= 0) mem[i] = wd & wmask[i];
    #1;
    cmp_byte("rvalid_q", {7'h0, rd}, {7'h0, rvalid_q});
    cmp_byte("rdata_q", erd, rdata_q);
    cmp_cfg(exp_cfg());
  endtask : op

  task automatic read_all();
    for (int a = 8'h20; a <= 8'h27; a++) op(1'b0, 1'b1, a[7:0], 8'h00, 1'b0);
  endtask : read_all

  task automatic tally_and_finish();
    $display("Checks done %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence: defaults, masks, field codes, buffering, random, reset.
  initial begin
    rng = 32'h28dc;
    rstn = 1'b0;
    req = '0;
    div_update = 1'b0;
    model_reset();
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    read_all();
    // Every register written all ones then all zeros, read after each.
    for (int i = 0; i < SROCR_NREG; i++) begin
      op(1'b1, 1'b0, SROCR_OFS_TAB[i], 8'hff, 1'b0);
      op(1'b0, 1'b1, SROCR_OFS_TAB[i], 8'h00, 1'b0);
      op(1'b1, 1'b1, SROCR_OFS_TAB[i], 8'h00, 1'b0);
      op(1'b0, 1'b1, SROCR_OFS_TAB[i], 8'h00, 1'b0);
    end
    // All division codes, reserved code included, with feedback toggling.
    for (int k = 0; k < 8; k++) begin
      op(1'b1, 1'b0, 8'h24, {k[0], k[2:0], 4'hf}, 1'b0);
      op(1'b0, 1'b1, 8'h24, 8'h00, 1'b0);
    end
    // Power, enable and doubler codes, read in the same cycle as written.
    for (int k = 0; k < 16; k++) begin
      op(1'b1, 1'b1, 8'h25, k[7:0], 1'b0);
    end
    // Buffered division: stored at once, active only on an update.
    op(1'b1, 1'b0, 8'h25, 8'h20, 1'b0);
    op(1'b1, 1'b0, 8'h24, 8'hb0, 1'b0);
    repeat (3) op(1'b0, 1'b1, 8'h24, 8'h00, 1'b0);
    op(1'b1, 1'b0, 8'h24, 8'he0, 1'b1);
    op(1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    op(1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
    op(1'b1, 1'b0, 8'h24, 8'h50, 1'b0);
    op(1'b1, 1'b0, 8'h25, 8'h07, 1'b0);
    op(1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    // Random traffic over the bank and its unmapped neighbours.
    repeat (300) begin
      rng = xs(rng);
      op(rng[0], rng[1], 8'h20 + rng[4:2], rng[15:8], rng[16]);
    end
    // A second reset in mid-run brings back every default at once.
    rstn = 1'b0;
    model_reset();
    #2;
    cmp_cfg(exp_cfg());
    cmp_byte("rvalid_q", 8'h00, {7'h0, rvalid_q});
    cmp_byte("rdata_q", 8'h00, rdata_q);
    @(posedge clk);
    #1 rstn = 1'b1;
    read_all();
    tally_and_finish();
  end

endmodule : srocr_regs_tb
